/* rtl/charger_regs.sv */
`timescale 1ns/100ps
`default_nettype none
`include "charger_regs_defines.svh"

module charger_regs
  import charger_regs_pkg::*;
#(
  parameter int ADDR_W = 8
)(
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              ce,
  // ahb-lite slave
  input  wire logic              hsel,
  input  wire logic [ADDR_W-1:0] haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic [31:0]            hrdata,
  // analog side
  input  wire analog_in_t        analog_in,
  input  wire logic              input_regulation_active,
  input  wire logic              disable_pin_level,
  input  wire logic              over_temperature,
  input  wire logic              charge_done,
  input  wire logic              termination_enable,
  // control outputs
  output logic [2:0]             input_regulation_setpoint,
  output logic [2:0]             charge_current_ceiling,
  output logic [3:0]             regulation_voltage_ceiling,
  output logic                   thermal_current_limit,
  output logic                   irq
);

  // ----------------------------------------
  // elaboration check
  // ----------------------------------------
  // six index bits plus two byte bits reach the top register
  if (ADDR_W < 8) begin : g_bad_addr
    $error("charger_regs: ADDR_W must be at least 8");
  end

  // ----------------------------------------
  // state
  // ----------------------------------------
  regs_state_t s_q;
  regs_state_t s_d;

  logic [7:0] monitor;
  logic [7:0] mon_events;

  // ----------------------------------------
  // comparator capture
  // ----------------------------------------
  loop_monitor u_mon (
    .hclk               (hclk),
    .hresetn            (hresetn),
    .ce                 (ce),
    .raw                (analog_in),
    .charge_done        (charge_done),
    .termination_enable (termination_enable),
    .monitor_q          (monitor),
    .events_q           (mon_events)
  );

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // word index of an address, or an index no register uses
  function automatic logic [5:0] word_idx(input logic [ADDR_W-1:0] a);
    logic [5:0] idx;
    idx = a[7:2];
    if (a[1:0] != 2'b00)
      idx = 6'h3F;
    if (ADDR_W > 8) begin
      if ((a >> 8) != '0)
        idx = 6'h3F;
    end
    return idx;
  endfunction

  function automatic logic [31:0] zext8(input logic [7:0] v);
    return {24'h000000, v};
  endfunction

  // ----------------------------------------
  // next state
  // ----------------------------------------
  logic       take;
  logic [5:0] a_idx;
  logic [7:0] wbyte;
  logic [7:0] clr;
  logic [7:0] in_reg;
  logic [7:0] lim_reg;

  always_comb begin
    s_d    = s_q;
    take   = hsel & htrans[1] & hready;
    a_idx  = word_idx(haddr);
    wbyte  = hwdata[7:0];
    clr    = 8'h00;
    in_reg = 8'h00;
    lim_reg = 8'h00;

    if (ce) begin
      // data phase of a write taken last cycle
      if (s_q.wr_pend) begin
        case (s_q.wr_idx)
          `IN_REG_IDX: begin
            // bits 4:3 are status and bits 7:5 read zero; all are left untouched
            s_d.setpoint = wbyte[`IN_SETPT_LSB +: 3]; // RL2 RL15
          end
          `LIMIT_IDX: begin
            // bit 7 is dropped, so it cannot stick
            s_d.cur_ceil  = wbyte[`LIM_CUR_LSB +: 3]; // RL5 RL4
            s_d.volt_ceil = wbyte[`LIM_VOLT_LSB +: 4]; // RL6
          end
          `IRQ_CLR_IDX: begin
            clr = wbyte;
          end
          `IRQ_EN_IDX: begin
            s_d.irq_en = wbyte;
          end
          default: begin
            // loop status, status and unmapped: write ignored
            clr = 8'h00; // RL15
          end
        endcase
      end

      // new address phase
      s_d.wr_pend = take & hwrite & (hsize == `HSIZE_WORD);
      s_d.wr_idx  = a_idx;

      // sticky events, a set in the clearing cycle wins
      s_d.irq_stat = (s_q.irq_stat & ~clr) | mon_events;
      s_d.irq      = |(s_d.irq_stat & s_d.irq_en);

      // thermal fold-back request to the current loop
      s_d.thermal_limit = monitor[4] & ~over_temperature; // RL10

      // read values use the updated registers, so a read
      // right behind a write sees the written value
      in_reg = 8'h00;
      in_reg[`IN_ACTIVE_BIT] = input_regulation_active; // RL1
      in_reg[`IN_DISPIN_BIT] = disable_pin_level;
      in_reg[`IN_SETPT_LSB +: 3] = s_d.setpoint; // RL2

      lim_reg = {1'b0, s_d.cur_ceil, s_d.volt_ceil}; // RL4

      if (take & ~hwrite) begin
        case (a_idx)
          `IN_REG_IDX: begin
            s_d.rdata = zext8(in_reg);
          end
          `LIMIT_IDX: begin
            s_d.rdata = zext8(lim_reg);
          end
          `LOOP_IDX: begin
            s_d.rdata = zext8(monitor); // RL7 RL11 RL12 RL13 RL14
          end
          `IRQ_STAT_IDX: begin
            s_d.rdata = zext8(s_d.irq_stat);
          end
          `IRQ_EN_IDX: begin
            s_d.rdata = zext8(s_d.irq_en);
          end
          default: begin
            // clear register and holes read as zero
            s_d.rdata = 32'h00000000;
          end
        endcase
      end

      s_d.ready = 1'b1;
      s_d.resp  = 1'b0;
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q.wr_pend       <= 1'b0;
      s_q.wr_idx        <= 6'h00;
      s_q.setpoint      <= `SETPOINT_RST; // RL2
      s_q.cur_ceil      <= 3'(`LIMIT_RST >> `LIM_CUR_LSB); // RL3 RL5
      s_q.volt_ceil     <= 4'(`LIMIT_RST >> `LIM_VOLT_LSB); // RL3 RL6
      s_q.irq_stat      <= 8'h00;
      s_q.irq_en        <= `IRQ_EN_RST;
      s_q.irq           <= 1'b0;
      s_q.thermal_limit <= 1'b0;
      s_q.rdata         <= 32'h00000000;
      s_q.ready         <= 1'b1;
      s_q.resp          <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------
  // outputs, all straight from flops
  // ----------------------------------------
  assign hreadyout                  = s_q.ready;
  assign hresp                      = s_q.resp;
  assign hrdata                     = s_q.rdata;
  assign input_regulation_setpoint  = s_q.setpoint;
  assign charge_current_ceiling     = s_q.cur_ceil;
  assign regulation_voltage_ceiling = s_q.volt_ceil;
  assign thermal_current_limit      = s_q.thermal_limit;
  assign irq                        = s_q.irq;

endmodule // charger_regs
`default_nettype wire

/* rtl/charger_regs_defines.svh */
// Behaviour
// [RL1] Input-regulation bit 4 reads 1 while dynamic input-voltage control holds the supply at setpoint; read-only.
// [RL2] Input-regulation bits 2:0 are a read/write regulation setpoint that resets to 100.
// [RL3] The charge limit register resets to 40h.
// [RL4] Charge limit bit 7 always reads 0 whatever is written.
// [RL5] Charge limit bits 6:4 are a read/write charge-current ceiling that resets to 100.
// [RL6] Charge limit bits 3:0 are a read/write regulation-voltage ceiling that resets to 0000.
// [RL7] Loop status bit 7 copies the termination comparator.
// [RL8] Loop status bit 6 copies the battery voltage comparator, whatever mode picks its threshold.
// [RL9] Loop status bit 5 reads 1 while the linear pre-charger is on.
// [RL10] Loop status bit 4 is the thermal comparator; with it set and no over-temperature, current is limited.
// [RL11] Loop status bit 3 reads 0 while the charge-current loop is in control.
// [RL12] Loop status bit 2 reads 0 while the input-current loop is in control.
// [RL13] Loop status bit 1 reads 1 once the input supply is validated.
// [RL14] Loop status bit 0 is set once the voltage loop acted since plug-in, and 0 if never or done with termination.
// [RL15] Host writes to read-only bits are ignored.
`ifndef CHARGER_REGS_DEFINES_SVH
`define CHARGER_REGS_DEFINES_SVH

// ----------------------------------------
// register indices, byte address is four times
// ----------------------------------------
`define IN_REG_IDX     6'h05
`define LIMIT_IDX      6'h06
`define LOOP_IDX       6'h10
`define IRQ_STAT_IDX   6'h11
`define IRQ_CLR_IDX    6'h12
`define IRQ_EN_IDX     6'h13

// ----------------------------------------
// field positions
// ----------------------------------------
`define IN_ACTIVE_BIT  4
`define IN_DISPIN_BIT  3
`define IN_SETPT_LSB   0
`define LIM_CUR_LSB    4
`define LIM_VOLT_LSB   0

// ----------------------------------------
// reset values and the word transfer size
// ----------------------------------------
`define SETPOINT_RST   3'h4
`define LIMIT_RST      8'h40
`define IRQ_EN_RST     8'h00
`define HSIZE_WORD     3'h2

`endif

/* rtl/charger_regs_pkg.sv */
package charger_regs_pkg;

  // raw comparator and loop levels from the analog side
  typedef struct packed {
    logic termination_comparator_flag;
    logic battery_voltage_comparator_flag;
    logic linear_precharge_on;
    logic thermal_comparator_flag;
    logic charge_current_loop_flag;
    logic input_current_loop_flag;
    logic input_supply_valid;
    logic constant_voltage_loop;
  } analog_in_t;

  typedef struct packed {
    logic [7:0] monitor;
    logic [7:0] events;
    logic       supply_prev;
    logic       cv_seen;
  } mon_state_t;

  typedef struct packed {
    logic        wr_pend;
    logic [5:0]  wr_idx;
    logic [2:0]  setpoint;
    logic [2:0]  cur_ceil;
    logic [3:0]  volt_ceil;
    logic [7:0]  irq_stat;
    logic [7:0]  irq_en;
    logic        irq;
    logic        thermal_limit;
    logic [31:0] rdata;
    logic        ready;
    logic        resp;
  } regs_state_t;

endpackage

/* rtl/loop_monitor.sv */
`timescale 1ns/100ps
`default_nettype none
`include "charger_regs_defines.svh"

module loop_monitor
  import charger_regs_pkg::*;
(
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       ce,
  input  wire analog_in_t raw,
  input  wire logic       charge_done,
  input  wire logic       termination_enable,
  output logic [7:0]      monitor_q,
  output logic [7:0]      events_q
);

  mon_state_t s_q;
  mon_state_t s_d;
  logic       plug_in;
  logic       cv_flag;

  always_comb begin
    s_d = s_q;
    plug_in = raw.input_supply_valid & ~s_q.supply_prev;
    cv_flag = 1'b0;
    if (ce) begin
      s_d.supply_prev = raw.input_supply_valid;
      // plug-in restarts history, but a loop active in that cycle still counts
      if (plug_in)
        s_d.cv_seen = raw.constant_voltage_loop; // RL14
      else if (raw.constant_voltage_loop)
        s_d.cv_seen = 1'b1; // RL14
      cv_flag = s_d.cv_seen & ~(charge_done & termination_enable); // RL14
      s_d.monitor = {raw.termination_comparator_flag, // RL7
                     raw.battery_voltage_comparator_flag, // RL8
                     raw.linear_precharge_on, // RL9
                     raw.thermal_comparator_flag, // RL10
                     raw.charge_current_loop_flag, // RL11
                     raw.input_current_loop_flag, // RL12
                     raw.input_supply_valid, // RL13
                     cv_flag};
      s_d.events = s_d.monitor ^ s_q.monitor;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign monitor_q = s_q.monitor;
  assign events_q  = s_q.events;

endmodule // loop_monitor
`default_nettype wire

/* sim/charger_regs_checker.sv */
`timescale 1ns/100ps
`default_nettype none
`include "charger_regs_defines.svh"
module charger_regs_checker
  import charger_regs_pkg::*;
#(
  parameter int ADDR_W = 8
)(
  input wire logic              hclk,
  input wire logic              hresetn,
  input wire logic              ce,
  input wire logic              hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0]        htrans,
  input wire logic              hwrite,
  input wire logic [2:0]        hsize,
  input wire logic [31:0]       hwdata,
  input wire logic              hready,
  input wire logic              hreadyout,
  input wire logic              hresp,
  input wire logic [31:0]       hrdata,
  input wire analog_in_t        analog_in,
  input wire logic              input_regulation_active,
  input wire logic              disable_pin_level,
  input wire logic              over_temperature,
  input wire logic              charge_done,
  input wire logic              termination_enable,
  input wire logic [2:0]        input_regulation_setpoint,
  input wire logic [2:0]        charge_current_ceiling,
  input wire logic [3:0]        regulation_voltage_ceiling,
  input wire logic              thermal_current_limit,
  input wire logic              irq
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence rd_at(a);
    hsel && htrans == 2'h2 && !hwrite && hready && haddr == a;
  endsequence
  sequence wr_at(a);
    hsel && htrans == 2'h2 && hwrite && hready && hsize == 3'h2 && haddr == a;
  endsequence
  // ---------------------------------
  // register side
  // ---------------------------------
  reset_value_a: assert property ($rose(hresetn) |-> input_regulation_setpoint == 3'h4
    && charge_current_ceiling == 3'h4 && regulation_voltage_ceiling == 4'h0) else $error("reset value wrong");
  lim_wr_a: assert property (wr_at(8'h18) |=> ##1 charge_current_ceiling == $past(hwdata[6:4])
    && regulation_voltage_ceiling == $past(hwdata[3:0])) else $error("limit write lost");
  setpoint_wr_a: assert property (wr_at(8'h14) |=> ##1 input_regulation_setpoint == $past(hwdata[2:0]))
    else $error("setpoint write lost");
  lim_rd_a: assert property (rd_at(8'h18) |=> hrdata[31:7] == 25'h0)
    else $error("limit top bit set");
  in_rd_a: assert property (rd_at(8'h14) |=> hrdata[4] == $past(input_regulation_active))
    else $error("regulation flag wrong");
  // status read is two flops behind the analog levels
  loop_rd_a: assert property (rd_at(8'h40) ##0 $past(hresetn, 2) |=> hrdata[7:1] == $past(analog_in[7:1], 2))
    else $error("loop status wrong");
  // a frozen clock enable holds the flag, so both stages must have run
  thermal_limit_a: assert property ($past(hresetn, 2) && $past(ce) && $past(ce, 2) |-> thermal_current_limit ==
    ($past(analog_in.thermal_comparator_flag, 2) && !$past(over_temperature))) else $error("thermal limit wrong");
  cv_mask_a: assert property (rd_at(8'h40) ##0 (charge_done && termination_enable && $past(charge_done))
    ##0 $past(termination_enable) |=> !hrdata[0]) else $error("voltage loop flag not masked");
  okay_resp_a: assert property (hreadyout && !hresp) else $error("bus answer not ready and okay");
endmodule // charger_regs_checker
bind charger_regs charger_regs_checker #(.ADDR_W(ADDR_W)) i_charger_regs_checker (.*);
`default_nettype wire

/* sim/ahb_host.sv */
`timescale 1ns/100ps
`default_nettype none
module ahb_host (
  input  wire logic        hclk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic [7:0]       haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata
);
  event        got;
  logic [31:0] rd_v;
  initial begin
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end
  // iff samples hready before this edge's updates land
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    @(posedge hclk iff hready);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk iff hready);
    rd_v = hrdata;
    hwdata <= ~d;
    if (!w) -> got;
  endtask
endmodule // ahb_host
`default_nettype wire

/* sim/charger_regs_test.sv */
`timescale 1ns/100ps
`default_nettype none
module charger_regs_test;
  import charger_regs_pkg::*;
  logic        hclk, hresetn, ce, hsel, hwrite, hready, ira, dpin, ot, cdone, term_en, tlim, irq;
  logic [7:0]  haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize, setpt, cc;
  logic [3:0]  vc;
  logic [31:0] hwdata, hrdata, d, a;
  analog_in_t  ain;
  logic [63:0] exp_q[$];
  int          n_errors, cmp_count, cyc;
  charger_regs i_charger_regs (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
    .hresp(), .hrdata(hrdata), .analog_in(ain), .input_regulation_active(ira), .disable_pin_level(dpin),
    .over_temperature(ot), .charge_done(cdone), .termination_enable(term_en), .input_regulation_setpoint(setpt),
    .charge_current_ceiling(cc), .regulation_voltage_ceiling(vc), .thermal_current_limit(tlim), .irq(irq));
  ahb_host i_ahb_host (.hclk(hclk), .hready(hready), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  // ---------------------------------
  // checking
  // ---------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
    cmp_count++;
    if ((got & m) !== (exp & m)) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic summarize;
    $display("errors=%0d compares=%0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic rd(input logic [7:0] ad, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back({m, e});
    i_ahb_host.xfer(1'b0, ad, 32'h0);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
  endtask
  always @(i_ahb_host.got) begin : watch
    logic [63:0] n;
    n = exp_q.pop_front();
    chk(i_ahb_host.rd_v, n[31:0], n[63:32]);
  end
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 4000) begin
      n_errors++;
      summarize();
    end
  end
  // ---------------------------------
  // scenarios
  // ---------------------------------
  initial begin
    void'($urandom(65));
    hresetn = 1'b0; ce = 1'b1; ain = '0; ira = 1'b1; dpin = 1'b0; ot = 1'b0; cdone = 1'b0; term_en = 1'b0;
    tick(6);
    hresetn <= 1'b1;
    tick(1);
    rd(8'h18, 32'h40, 32'hFFFFFFFF);
    rd(8'h14, 32'h14, 32'hFFFFFFFF);
    for (int i = 0; i < 6; i++) begin
      d = $urandom;
      ira <= i[0];
      dpin <= i[1];
      i_ahb_host.xfer(1'b1, 8'h18, d | 32'h80);
      rd(8'h18, d & 32'h7F, 32'hFFFFFFFF);
      i_ahb_host.xfer(1'b1, 8'h14, d);
      rd(8'h14, {27'h0, i[0], i[1], d[2:0]}, 32'hFFFFFFFF);
    end
    for (int i = 0; i < 8; i++) begin
      a = $urandom & 32'hFF;
      ain <= analog_in_t'(a[7:0]);
      tick(2);
      i_ahb_host.xfer(1'b1, 8'h40, ~a);
      rd(8'h40, a, 32'hFFFFFFFE);
    end
    ain <= 8'h00;
    tick(2);
    ain <= 8'h02;
    tick(3);
    rd(8'h40, 32'h02, 32'hFF);
    ain <= 8'h03;
    tick(3);
    rd(8'h40, 32'h03, 32'hFF);
    cdone <= 1'b1;
    term_en <= 1'b1;
    tick(2);
    rd(8'h40, 32'h02, 32'hFF);
    term_en <= 1'b0;
    tick(2);
    rd(8'h40, 32'h03, 32'hFF);
    ain <= 8'h13;
    tick(3);
    chk({31'h0, tlim}, 32'h1, 32'h1);
    ot <= 1'b1;
    tick(2);
    chk({31'h0, tlim}, 32'h0, 32'h1);
    // clock enable low: the thermal flag must not follow the input
    ce <= 1'b0;
    ot <= 1'b0;
    tick(3);
    chk({31'h0, tlim}, 32'h0, 32'h1);
    ce <= 1'b1;
    tick(2);
    chk({31'h0, tlim}, 32'h1, 32'h1);
    // clear events left by earlier scenarios before enabling
    i_ahb_host.xfer(1'b1, 8'h48, 32'hFF);
    i_ahb_host.xfer(1'b1, 8'h4C, 32'h20);
    tick(2);
    chk({31'h0, irq}, 32'h0, 32'h1);
    ain <= 8'h37;
    tick(3);
    chk({31'h0, irq}, 32'h1, 32'h1);
    rd(8'h44, 32'h24, 32'hFF);
    i_ahb_host.xfer(1'b1, 8'h48, 32'h20);
    tick(2);
    chk({31'h0, irq}, 32'h0, 32'h1);
    rd(8'h4C, 32'h20, 32'hFFFFFFFF);
    rd(8'h48, 32'h0, 32'hFFFFFFFF);
    rd(8'h7C, 32'h0, 32'hFFFFFFFF);
    tick(2);
    summarize();
  end
endmodule // charger_regs_test
`default_nettype wire
